// >>> rtl/usdp_fifo.sv
/*
 * Flip-flop FIFO; a push when full is taken only if a pop frees a slot in the same cycle.
 * Assumes the owner holds no request during reset.
 */
`timescale 1ns/100ps
module usdp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// queue port
	usdp_fifo_if.store f
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} usdp_fifo_st_t;

	usdp_fifo_st_t s_r;
	usdp_fifo_st_t s_nxt;
	logic do_pop;
	logic do_push;

	assign do_pop = f.pop && (s_r.cnt != '0);
	assign do_push = f.push && ((s_r.cnt != FULL_CNT) || do_pop);
	assign f.head = s_r.mem[s_r.rp];
	assign f.full = (s_r.cnt == FULL_CNT);
	assign f.empty = (s_r.cnt == '0);
	assign f.accept = do_push && !f.flush;

	always_comb
	begin
		s_nxt = s_r;
		if (f.flush)
		begin
			s_nxt.wp = '0;
			s_nxt.rp = '0;
			s_nxt.cnt = '0;
		end
		else
		begin
			if (do_push)
			begin
				s_nxt.mem[s_r.wp] = f.push_data;
				s_nxt.wp = (s_r.wp == LAST_PTR) ? '0 : s_r.wp + 1'b1;
			end
			if (do_pop)
				s_nxt.rp = (s_r.rp == LAST_PTR) ? '0 : s_r.rp + 1'b1;
			if (do_push && !do_pop)
				s_nxt.cnt = s_r.cnt + 1'b1;
			else if (do_pop && !do_push)
				s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule

// >>> rtl/usdp_fifo_if.sv
/*
 * Push/pop bundle between the data port and one of its FIFOs.
 * Assumes the owner drives requests and the store answers in the same cycle.
 */
`timescale 1ns/100ps
interface usdp_fifo_if #(parameter int W = 8);
	logic push;
	logic [W-1:0] push_data;
	logic pop;
	logic flush;
	logic [W-1:0] head;
	logic full;
	logic empty;
	logic accept;
	modport owner (output push, push_data, pop, flush, input head, full, empty, accept);
	modport store (input push, push_data, pop, flush, output head, full, empty, accept);
endinterface

// >>> rtl/usdp_irq.sv
/*
 * Sticky interrupt status with enable mask and write-one-to-clear; a set beats a clear.
 * Assumes event inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
module usdp_irq
	import usdp_pkg::*;
#(
	parameter int N = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// events and register writes
	input wire logic [N-1:0] event_i,
	input wire logic en_wr,
	input wire logic clr_wr,
	input wire logic [N-1:0] wdata,
	// state and request
	output logic [N-1:0] status,
	output logic [N-1:0] enable,
	output logic irq
);
	typedef struct packed {
		logic [N-1:0] status;
		logic [N-1:0] enable;
	} usdp_irq_st_t;

	usdp_irq_st_t s_r;
	usdp_irq_st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (en_wr)
			s_nxt.enable = wdata;
		if (clr_wr)
			s_nxt.status = s_r.status & ~wdata;
		s_nxt.status = s_nxt.status | event_i;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r.status <= '0;
			s_r.enable <= N'(IRQ_EN_RST);
		end
		else
			s_r <= s_nxt;
	end

	assign status = s_r.status;
	assign enable = s_r.enable;
	assign irq = |(s_r.status & s_r.enable);
endmodule

// >>> rtl/usdp_pkg.sv
/*
 * Constants, field positions, reset values and the state type of the shadow data port.
 * Assumes a 32-bit APB bus with zero-wait answers and a receiver/transmitter on the same clock.
 */
package usdp_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int IRQ_N = 3;

	localparam logic [31:0] ADDR_DATA = 32'h5000_1068;
	localparam logic [31:0] ADDR_LINE_STAT = 32'h5000_1100;
	localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_1104;
	localparam logic [31:0] ADDR_MODE = 32'h5000_1108;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'h5000_110C;
	localparam logic [31:0] ADDR_IRQ_EN = 32'h5000_1110;
	localparam logic [31:0] ADDR_IRQ_CLR = 32'h5000_1114;

	localparam int STAT_READY_BIT = 0;
	localparam int STAT_OVR_BIT = 1;
	localparam int STAT_TXE_BIT = 5;
	localparam int CTRL_FIFO_EN_BIT = 0;
	localparam int MODE_IR_BIT = 0;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_OE_BIT = 1;
	localparam int IRQ_TXE_BIT = 2;

	localparam logic FIFO_EN_RST = 1'h0;
	localparam logic IR_MODE_RST = 1'h0;
	localparam logic [IRQ_N-1:0] IRQ_EN_RST = 3'h0;

	typedef struct packed {
		logic [DATA_W-1:0] rx_hold;
		logic rx_full;
		logic [DATA_W-1:0] tx_hold;
		logic tx_full;
		logic overrun;
		logic fifo_en;
		logic ir_mode;
		logic tx_empty_d;
	} usdp_top_st_t;
endpackage

// >>> rtl/usdp_top.sv
/*
 * Shadow receive-buffer / transmit-holding data port with line status, FIFO control and interrupts on APB.
 * Assumes receiver and transmitter sit on CLK, deliver and take whole bytes, and handle framing and pins.
 */
`timescale 1ns/100ps
module usdp_top
	import usdp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// received characters
	input wire logic RX_SIN_VALID,
	input wire logic [DATA_W-1:0] RX_SIN_DATA,
	input wire logic RX_SIR_VALID,
	input wire logic [DATA_W-1:0] RX_SIR_DATA,
	// characters to send
	output logic TX_VALID,
	output logic [DATA_W-1:0] TX_DATA,
	output logic TX_IR_SEL,
	input wire logic TX_READY,
	// interrupt
	output logic IRQ
);
	usdp_top_st_t s_r;
	usdp_top_st_t s_nxt;

	usdp_fifo_if #(.W(DATA_W)) rx_if ();
	usdp_fifo_if #(.W(DATA_W)) tx_if ();

	logic acc;
	logic wr;
	logic rd;
	logic hit_data;
	logic hit_line;
	logic hit_ctrl;
	logic hit_mode;
	logic hit_stat;
	logic hit_en;
	logic hit_clr;
	logic mapped;
	logic data_rd;
	logic data_wr;
	logic line_rd;
	logic ctrl_wr;
	logic flush;
	logic rx_vld;
	logic [DATA_W-1:0] rx_byte;
	logic [DATA_W-1:0] wbyte;
	logic rx_ready;
	logic tx_empty;
	logic ov_ev;
	logic rx_ev;
	logic [31:0] line_val;
	logic [IRQ_N-1:0] irq_ev;
	logic [IRQ_N-1:0] irq_stat;
	logic [IRQ_N-1:0] irq_en;

	// zero-wait apb decode
	assign PREADY = 1'b1;
	assign acc = PSEL && PENABLE;
	assign wr = acc && PWRITE;
	assign rd = acc && !PWRITE;
	assign hit_data = (PADDR == ADDR_DATA);
	assign hit_line = (PADDR == ADDR_LINE_STAT);
	assign hit_ctrl = (PADDR == ADDR_FIFO_CTRL);
	assign hit_mode = (PADDR == ADDR_MODE);
	assign hit_stat = (PADDR == ADDR_IRQ_STAT);
	assign hit_en = (PADDR == ADDR_IRQ_EN);
	assign hit_clr = (PADDR == ADDR_IRQ_CLR);
	assign mapped = hit_data || hit_line || hit_ctrl || hit_mode || hit_stat || hit_en || hit_clr;
	assign PSLVERR = acc && !mapped;
	assign data_rd = rd && hit_data;
	assign data_wr = wr && hit_data;
	assign line_rd = rd && hit_line;
	assign ctrl_wr = wr && hit_ctrl;
	assign wbyte = PWDATA[DATA_W-1:0];

	// infrared mode picks the receive source
	assign rx_vld = s_r.ir_mode ? RX_SIR_VALID : RX_SIN_VALID;
	assign rx_byte = s_r.ir_mode ? RX_SIR_DATA : RX_SIN_DATA;

	// toggling fifo enable empties both queues
	assign flush = ctrl_wr && (PWDATA[CTRL_FIFO_EN_BIT] != s_r.fifo_en);

	assign rx_if.push = s_r.fifo_en && rx_vld;
	assign rx_if.push_data = rx_byte;
	assign rx_if.pop = s_r.fifo_en && data_rd;
	assign rx_if.flush = flush;
	assign tx_if.push = s_r.fifo_en && data_wr;
	assign tx_if.push_data = wbyte;
	assign tx_if.pop = s_r.fifo_en && TX_READY;
	assign tx_if.flush = flush;

	usdp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(CLK),
		.rstn(RSTN),
		.f(rx_if.store)
	);

	usdp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(CLK),
		.rstn(RSTN),
		.f(tx_if.store)
	);

	assign rx_ready = s_r.fifo_en ? !rx_if.empty : s_r.rx_full;
	assign tx_empty = s_r.fifo_en ? tx_if.empty : !s_r.tx_full;
	assign ov_ev = s_r.fifo_en ? (rx_if.push && !rx_if.accept) : (rx_vld && s_r.rx_full && !data_rd);
	assign rx_ev = s_r.fifo_en ? rx_if.accept : rx_vld;

	assign TX_VALID = s_r.fifo_en ? !tx_if.empty : s_r.tx_full;
	assign TX_DATA = s_r.fifo_en ? tx_if.head : s_r.tx_hold;
	assign TX_IR_SEL = s_r.ir_mode;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tx_empty_d = tx_empty;
		if (!s_r.fifo_en)
		begin
			if (data_rd)
				s_nxt.rx_full = 1'b0;
			// a fresh character overwrites an unread one
			if (rx_vld)
			begin
				s_nxt.rx_hold = rx_byte;
				s_nxt.rx_full = 1'b1;
			end
			if (TX_READY && s_r.tx_full)
				s_nxt.tx_full = 1'b0;
			// a write replaces any byte still pending
			if (data_wr)
			begin
				s_nxt.tx_hold = wbyte;
				s_nxt.tx_full = 1'b1;
			end
		end
		if (flush)
		begin
			s_nxt.rx_full = 1'b0;
			s_nxt.tx_full = 1'b0;
		end
		if (line_rd)
			s_nxt.overrun = 1'b0;
		if (ov_ev)
			s_nxt.overrun = 1'b1;
		if (ctrl_wr)
			s_nxt.fifo_en = PWDATA[CTRL_FIFO_EN_BIT];
		if (wr && hit_mode)
			s_nxt.ir_mode = PWDATA[MODE_IR_BIT];
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			s_r <= '0;
			s_r.fifo_en <= FIFO_EN_RST;
			s_r.ir_mode <= IR_MODE_RST;
			s_r.tx_empty_d <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign irq_ev[IRQ_RX_BIT] = rx_ev;
	assign irq_ev[IRQ_OE_BIT] = ov_ev;
	assign irq_ev[IRQ_TXE_BIT] = tx_empty && !s_r.tx_empty_d;

	usdp_irq #(.N(IRQ_N)) u_irq (
		.clk(CLK),
		.rstn(RSTN),
		.event_i(irq_ev),
		.en_wr(wr && hit_en),
		.clr_wr(wr && hit_clr),
		.wdata(PWDATA[IRQ_N-1:0]),
		.status(irq_stat),
		.enable(irq_en),
		.irq(IRQ)
	);

	always_comb
	begin
		line_val = '0;
		line_val[STAT_READY_BIT] = rx_ready;
		line_val[STAT_OVR_BIT] = s_r.overrun;
		line_val[STAT_TXE_BIT] = tx_empty;
	end

	// read mux; reserved and unmapped bits read zero
	always_comb
	begin
		PRDATA = '0;
		if (rd)
		begin
			if (hit_data)
				PRDATA[DATA_W-1:0] = s_r.fifo_en ? rx_if.head : s_r.rx_hold;
			else if (hit_line)
				PRDATA = line_val;
			else if (hit_ctrl)
				PRDATA[CTRL_FIFO_EN_BIT] = s_r.fifo_en;
			else if (hit_mode)
				PRDATA[MODE_IR_BIT] = s_r.ir_mode;
			else if (hit_stat)
				PRDATA[IRQ_N-1:0] = irq_stat;
			else if (hit_en)
				PRDATA[IRQ_N-1:0] = irq_en;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	property p_alias_decode;
		acc && hit_data |-> !PSLVERR && PREADY;
	endproperty
	a_alias_decode: assert property (p_alias_decode) else $error("data alias not answered cleanly");

	property p_rx_capture;
		!s_r.fifo_en && rx_vld && !flush |=> s_r.rx_hold == $past(rx_byte) && rx_ready;
	endproperty
	a_rx_capture: assert property (p_rx_capture) else $error("received byte not held");

	property p_ready_after_read;
		!s_r.fifo_en && data_rd && !rx_vld |=> !rx_ready;
	endproperty
	a_ready_after_read: assert property (p_ready_after_read) else $error("data ready stays after read");

	property p_overwrite_overrun;
		!s_r.fifo_en && rx_vld && s_r.rx_full && !data_rd |=> s_r.overrun && s_r.rx_hold == $past(rx_byte);
	endproperty
	a_overwrite_overrun: assert property (p_overwrite_overrun) else $error("overwrite without overrun");

	property p_fifo_read;
		s_r.fifo_en && data_rd |-> PRDATA[DATA_W-1:0] == rx_if.head && rx_if.pop;
	endproperty
	a_fifo_read: assert property (p_fifo_read) else $error("fifo head not returned and popped");

	property p_rx_full_drop;
		rx_if.push && rx_if.full && !rx_if.pop |-> !rx_if.accept ##1 s_r.overrun;
	endproperty
	a_rx_full_drop: assert property (p_rx_full_drop) else $error("full receive fifo took a byte");

	property p_ir_select;
		wr && hit_mode |=> TX_IR_SEL == $past(PWDATA[MODE_IR_BIT]);
	endproperty
	a_ir_select: assert property (p_ir_select) else $error("infrared select not updated");

	property p_tx_empty_clear;
		!s_r.fifo_en && data_wr && !flush && !ctrl_wr |=> !tx_empty && TX_VALID;
	endproperty
	a_tx_empty_clear: assert property (p_tx_empty_clear) else $error("empty flag not cleared by write");

	property p_tx_overwrite;
		!s_r.fifo_en && data_wr && !ctrl_wr |=> TX_DATA == $past(wbyte);
	endproperty
	a_tx_overwrite: assert property (p_tx_overwrite) else $error("pending byte not replaced");

	property p_tx_room;
		tx_if.push && !tx_if.full && !flush |-> tx_if.accept;
	endproperty
	a_tx_room: assert property (p_tx_room) else $error("write refused with room left");

	property p_tx_full_drop;
		tx_if.push && tx_if.full && !tx_if.pop |-> !tx_if.accept;
	endproperty
	a_tx_full_drop: assert property (p_tx_full_drop) else $error("write into full transmit fifo");

	property p_reserved_zero;
		data_rd |-> PRDATA[31:DATA_W] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	c_fifo_overrun: cover property (rx_if.push && rx_if.full && !rx_if.pop);
	c_plain_overrun: cover property (!s_r.fifo_en && rx_vld && s_r.rx_full);
	c_tx_full: cover property (tx_if.push && tx_if.full);
	c_irq: cover property (IRQ);
	c_tx_overwrite: cover property (!s_r.fifo_en && data_wr && s_r.tx_full);

	// a new overrun in the same cycle as the status read keeps the flag
	property p_overrun_clear;
		line_rd && !ov_ev |=> !s_r.overrun;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared by status read");

	property p_tx_release;
		!s_r.fifo_en && TX_READY && s_r.tx_full && !data_wr && !flush |=> tx_empty && !TX_VALID;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("empty flag not set after byte taken");

	property p_rx_fifo_take;
		rx_if.push && !rx_if.full && !flush |-> rx_if.accept;
	endproperty
	a_rx_fifo_take: assert property (p_rx_fifo_take) else $error("receive fifo refused a byte with room");

	property p_irq_set_wins;
		rx_ev |=> irq_stat[IRQ_RX_BIT];
	endproperty
	a_irq_set_wins: assert property (p_irq_set_wins) else $error("receive event lost in interrupt status");
endmodule

// >>> test/testbench.sv
/*
 * Self-checking bench of the shadow data port over APB with a line-side model.
 * Assumes zero-wait APB answers are waited for, not counted; DEPTH is set small.
 */
`timescale 1ns/100ps
module testbench;
	import usdp_pkg::*;
	localparam int D = 4;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [31:0] PADDR = 32'h0;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, SV, RV, TV, TR, TIR, IRQ;
	logic [7:0] SD, RD, TD;
	logic stall = 1'b1;
	logic [31:0] rd;
	logic er;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;

	always #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end

	usdp_top #(.DEPTH(D)) dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.RX_SIN_VALID(SV), .RX_SIN_DATA(SD), .RX_SIR_VALID(RV), .RX_SIR_DATA(RD),
		.TX_VALID(TV), .TX_DATA(TD), .TX_IR_SEL(TIR), .TX_READY(TR), .IRQ(IRQ));
	usdp_line_model lm (.clk(CLK), .sin_valid(SV), .sin_data(SD), .sir_valid(RV), .sir_data(RD),
		.tx_valid(TV), .tx_data(TD), .tx_ready(TR), .stall(stall));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rc(input string nm, input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task waitn(input int n);
		while (lm.got.size() < n)
			@(posedge CLK);
	endtask

	task close_out();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		rc("data", ADDR_DATA, 32'h0);
		rc("fifo ctrl", ADDR_FIFO_CTRL, 32'h0);
		apb(1'b0, 32'h5000_1200, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test reset done");

		lm.send(1'b0, 8'hA5);
		rc("line stat", ADDR_LINE_STAT, 32'h21);
		rc("data", ADDR_DATA, 32'hA5);
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		lm.send(1'b0, 8'h01);
		lm.send(1'b0, 8'h02);
		rc("line stat", ADDR_LINE_STAT, 32'h23);
		rc("data", ADDR_DATA, 32'h02);
		$display("test rx single done");

		wr(ADDR_IRQ_CLR, 32'h7);
		rc("irq stat", ADDR_IRQ_STAT, 32'h0);
		wr(ADDR_IRQ_EN, 32'h1);
		lm.send(1'b0, 8'h33);
		@(negedge CLK);
		chk("irq", 32'h1, {31'h0, IRQ});
		rc("data", ADDR_DATA, 32'h33);
		wr(ADDR_IRQ_CLR, 32'h1);
		@(negedge CLK);
		chk("irq", 32'h0, {31'h0, IRQ});
		wr(ADDR_IRQ_EN, 32'h0);
		lm.send(1'b0, 8'h34);
		rc("irq stat", ADDR_IRQ_STAT, 32'h1);
		chk("irq", 32'h0, {31'h0, IRQ});
		rc("irq clr", ADDR_IRQ_CLR, 32'h0);
		rc("data", ADDR_DATA, 32'h34);
		$display("test irq done");

		wr(ADDR_MODE, 32'h1);
		lm.send(1'b0, 8'h11);
		lm.send(1'b1, 8'h5A);
		rc("line stat", ADDR_LINE_STAT, 32'h21);
		rc("data", ADDR_DATA, 32'h5A);
		chk("ir sel", 32'h1, {31'h0, TIR});
		wr(ADDR_MODE, 32'h0);
		$display("test infrared done");

		lm.got.delete();
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		wr(ADDR_DATA, 32'h0000_FF41);
		rc("line stat", ADDR_LINE_STAT, 32'h00);
		wr(ADDR_DATA, 32'h0000_FF42);
		@(negedge CLK);
		chk("tx data", 32'h42, {24'h0, TD});
		chk("ir sel", 32'h0, {31'h0, TIR});
		stall <= 1'b0;
		waitn(1);
		repeat (5) @(posedge CLK);
		chk("tx count", 32'h1, lm.got.size());
		chk("tx byte", 32'h42, {24'h0, lm.got[0]});
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		$display("test tx single done");

		wr(ADDR_FIFO_CTRL, 32'h1);
		for (int i = 0; i <= D; i++)
			lm.send(1'b0, 8'h10 + i[7:0]);
		rc("line stat", ADDR_LINE_STAT, 32'h23);
		for (int i = 0; i < D; i++)
			rc("rx fifo", ADDR_DATA, 32'h10 + i);
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		$display("test rx fifo done");

		stall <= 1'b1;
		lm.got.delete();
		for (int i = 0; i <= D; i++)
			wr(ADDR_DATA, 32'h30 + i);
		rc("line stat", ADDR_LINE_STAT, 32'h00);
		stall <= 1'b0;
		waitn(D);
		repeat (5) @(posedge CLK);
		chk("tx count", D, lm.got.size());
		for (int i = 0; i < D; i++)
			chk("tx fifo", 32'h30 + i, {24'h0, lm.got[i]});
		rc("line stat", ADDR_LINE_STAT, 32'h20);
		rc("irq stat", ADDR_IRQ_STAT, 32'h7);
		$display("test tx fifo done");
		close_out();
	end
endmodule

// >>> test/usdp_line_model.sv
/*
 * Line-side model: hands received bytes to the port and takes bytes to send.
 * Assumes it shares CLK with the port; stall holds off the transmit handshake.
 */
`timescale 1ns/100ps
module usdp_line_model
	import usdp_pkg::*;
(
	// clock
	input wire logic clk,
	// received bytes
	output logic sin_valid,
	output logic [DATA_W-1:0] sin_data,
	output logic sir_valid,
	output logic [DATA_W-1:0] sir_data,
	// bytes to send
	input wire logic tx_valid,
	input wire logic [DATA_W-1:0] tx_data,
	output logic tx_ready,
	input wire logic stall
);
	logic [DATA_W-1:0] got[$];
	initial
	begin
		sin_valid = 1'b0;
		sir_valid = 1'b0;
		sin_data = 8'h00;
		sir_data = 8'hFF;
		tx_ready = 1'b0;
	end
	// take a byte only at an edge with both sides high
	always @(posedge clk)
	begin
		tx_ready <= !stall;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
	// idle data lines show the inverse of the last byte
	task send(input logic ir, input logic [DATA_W-1:0] b);
		@(posedge clk);
		sin_valid <= !ir;
		sir_valid <= ir;
		sin_data <= b;
		sir_data <= b;
		@(posedge clk);
		sin_valid <= 1'b0;
		sir_valid <= 1'b0;
		sin_data <= ~b;
		sir_data <= ~b;
	endtask
endmodule
